/* File: design/l4m_port_flag_etype_matcher.sv */
`default_nettype none

module l4m_port_flag_etype_matcher
    import l4m_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_valid,
    input  wire logic              frame_is_tcp,
    input  wire logic              frame_is_udp,
    input  wire logic [15:0]       frame_src_port,
    input  wire logic [15:0]       frame_dst_port,
    input  wire logic [5:0]        frame_tcp_flags,
    input  wire logic [15:0]       frame_ethertype,
    output logic                   hit_valid,
    output logic                   hit
);

    l4m_state_type     state;
    l4m_state_type     next_state;
    logic [31:0]       cfg_mem [L4M_NUM_CFG];
    logic [31:0]       next_mem [L4M_NUM_CFG];
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              next_hit_valid;
    logic              next_hit;
    logic [15:0]       hit_count;
    logic [15:0]       next_hit_count;
    logic [L4M_IDX_W-1:0] idx;
    logic              mapped;
    logic [31:0]       status_word;

    l4m_cfg_if cfg_bus ();

    assign cfg_bus.cls       = cfg_mem[L4M_IDX_CTRL][L4M_CLS_LSB +: 2];
    assign cfg_bus.proto     = cfg_mem[L4M_IDX_CTRL][L4M_PROTO_LSB +: 2];
    assign cfg_bus.smode     = cfg_mem[L4M_IDX_CTRL][L4M_SMODE_LSB +: 2];
    assign cfg_bus.dmode     = cfg_mem[L4M_IDX_CTRL][L4M_DMODE_LSB +: 2];
    assign cfg_bus.emode     = cfg_mem[L4M_IDX_CTRL][L4M_EMODE_BIT];
    assign cfg_bus.flag_sel  = cfg_mem[L4M_IDX_FLAGS][11:0];
    assign cfg_bus.src_lo    = cfg_mem[L4M_IDX_SRC][L4M_LO_LSB +: 16];
    assign cfg_bus.src_hi    = cfg_mem[L4M_IDX_SRC][L4M_HI_LSB +: 16];
    assign cfg_bus.dst_lo    = cfg_mem[L4M_IDX_DST][L4M_LO_LSB +: 16];
    assign cfg_bus.dst_hi    = cfg_mem[L4M_IDX_DST][L4M_HI_LSB +: 16];
    assign cfg_bus.etype_val = cfg_mem[L4M_IDX_ETYPE][15:0];
    assign cfg_bus.f_tcp     = frame_is_tcp;
    assign cfg_bus.f_udp     = frame_is_udp;
    assign cfg_bus.f_src     = frame_src_port;
    assign cfg_bus.f_dst     = frame_dst_port;
    assign cfg_bus.f_flags   = frame_tcp_flags;
    assign cfg_bus.f_etype   = frame_ethertype;

    l4m_cmp u_cmp (
        .cfg (cfg_bus.cmp)
    );

    // apb decode: word aligned, within the six words
    assign idx    = paddr[2 +: L4M_IDX_W];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0)
                    && (idx <= L4M_IDX_STATUS);

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[L4M_ST_HIT_BIT]  = hit;
        status_word[L4M_ST_EBAD_BIT] = cfg_bus.etype_bad;
        status_word[L4M_ST_CNT_LSB +: 16] = hit_count;
    end

    always_comb
    begin
        next_state   = state;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_mem     = cfg_mem;
        unique case (state)
            L4M_ST_IDLE:
            begin
                if (psel && !penable)
                begin
                    next_state   = L4M_ST_ACCESS;
                    next_pready  = 1'b1;
                    next_pslverr = !mapped;
                    next_prdata  = 32'h0000_0000;
                    if (mapped && !pwrite)
                    begin
                        next_prdata = (idx == L4M_IDX_STATUS) ? status_word : cfg_mem[idx];
                    end
                end
            end
            L4M_ST_ACCESS:
            begin
                next_state = L4M_ST_IDLE;
                // status is read only, writes to it are dropped
                if (psel && penable && pwrite && mapped && idx < L4M_IDX_STATUS)
                begin
                    next_mem[idx] = l4m_merge(cfg_mem[idx], pwdata, pstrb, L4M_WMASK[idx]);
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= L4M_ST_IDLE;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            cfg_mem <= L4M_RESET;
        end
        else
        begin
            state   <= next_state;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            cfg_mem <= next_mem;
        end
    end

    always_comb
    begin
        next_hit_valid = frame_valid;
        next_hit       = frame_valid && cfg_bus.match;
        next_hit_count = hit_count;
        if (next_hit && hit_count != L4M_CNT_MAX)
        begin
            next_hit_count = hit_count + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hit_valid <= 1'b0;
            hit       <= 1'b0;
            hit_count <= 16'h0000;
        end
        else
        begin
            hit_valid <= next_hit_valid;
            hit       <= next_hit;
            hit_count <= next_hit_count;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic ip_tcp;
    logic ip_udp;
    assign ip_tcp = (cfg_bus.cls == L4M_CLS_IP) && (cfg_bus.proto == L4M_PR_TCP) && frame_is_tcp;
    assign ip_udp = (cfg_bus.cls == L4M_CLS_IP) && (cfg_bus.proto == L4M_PR_UDP) && frame_is_udp;

    property p_flag_needed(int i);
        frame_valid && ip_tcp && cfg_bus.flag_sel[2*i +: 2] == 2'b01 && !frame_tcp_flags[i]
            |=> hit_valid && !hit;
    endproperty

    chk_hit_latency: assert property (frame_valid |=> hit_valid ##1 (hit_valid == $past(frame_valid)))
        else $error("hit_valid does not follow frame_valid by one clock");
    chk_hit_without_valid: assert property (!frame_valid |=> !hit_valid && !hit)
        else $error("hit raised without a valid strobe");
    chk_src_exact_miss: assert property (frame_valid && (ip_tcp || ip_udp)
        && cfg_bus.smode == L4M_PM_EXACT && frame_src_port != cfg_bus.src_lo |=> !hit)
        else $error("exact source port mismatch produced a hit");
    chk_src_range_miss: assert property (frame_valid && (ip_tcp || ip_udp)
        && cfg_bus.smode == L4M_PM_RANGE
        && (frame_src_port < cfg_bus.src_lo || frame_src_port > cfg_bus.src_hi) |=> !hit)
        else $error("source port outside range produced a hit");
    chk_dst_exact_miss: assert property (frame_valid && (ip_tcp || ip_udp)
        && cfg_bus.dmode == L4M_PM_EXACT && frame_dst_port != cfg_bus.dst_lo |=> !hit)
        else $error("exact destination port mismatch produced a hit");
    chk_dst_range_miss: assert property (frame_valid && (ip_tcp || ip_udp)
        && cfg_bus.dmode == L4M_PM_RANGE
        && (frame_dst_port < cfg_bus.dst_lo || frame_dst_port > cfg_bus.dst_hi) |=> !hit)
        else $error("destination port outside range produced a hit");
    chk_fin_needed: assert property (p_flag_needed(L4M_FIN))
        else $error("fin required but clear, still a hit");
    chk_syn_needed: assert property (p_flag_needed(L4M_SYN))
        else $error("syn required but clear, still a hit");
    chk_rst_needed: assert property (p_flag_needed(L4M_RST))
        else $error("rst required but clear, still a hit");
    chk_psh_needed: assert property (p_flag_needed(L4M_PSH))
        else $error("psh required but clear, still a hit");
    chk_ack_needed: assert property (p_flag_needed(L4M_ACK))
        else $error("ack required but clear, still a hit");
    chk_urg_rejected: assert property (frame_valid && ip_tcp
        && cfg_bus.flag_sel[2*L4M_URG +: 2] == 2'b00 && frame_tcp_flags[L4M_URG] |=> !hit)
        else $error("urg set against a clear selector, still a hit");
    chk_etype_miss: assert property (frame_valid && cfg_bus.cls == L4M_CLS_ETYPE && cfg_bus.emode
        && (frame_ethertype != cfg_bus.etype_val || cfg_bus.etype_bad) |=> !hit)
        else $error("ethertype mismatch or illegal value produced a hit");
    chk_etype_any_hits: assert property (frame_valid && cfg_bus.cls == L4M_CLS_ETYPE
        && !cfg_bus.emode |=> hit)
        else $error("ethertype don't-care entry missed a frame");
    chk_any_class_hits: assert property (frame_valid && cfg_bus.cls == L4M_CLS_ANY |=> hit)
        else $error("catch-all entry missed a frame");
    chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle after setup");

    cov_exact_hit: cover property (frame_valid && ip_tcp && cfg_bus.smode == L4M_PM_EXACT ##1 hit);
    cov_range_hit: cover property (frame_valid && ip_udp && cfg_bus.dmode == L4M_PM_RANGE ##1 hit);
    cov_etype_hit: cover property (frame_valid && cfg_bus.cls == L4M_CLS_ETYPE
        && cfg_bus.emode ##1 hit);
    cov_apb_back2back: cover property (psel && penable && pready ##1 psel && !penable);

endmodule : l4m_port_flag_etype_matcher

`default_nettype wire

/* File: design/l4m_pkg.sv */
`default_nettype none

package l4m_pkg;

    // register word offsets (byte addresses)
    localparam logic [7:0] L4M_CTRL_OFS   = 8'h00;
    localparam logic [7:0] L4M_FLAGS_OFS  = 8'h04;
    localparam logic [7:0] L4M_SRC_OFS    = 8'h08;
    localparam logic [7:0] L4M_DST_OFS    = 8'h0C;
    localparam logic [7:0] L4M_ETYPE_OFS  = 8'h10;
    localparam logic [7:0] L4M_STATUS_OFS = 8'h14;

    localparam int         L4M_IDX_W      = 3;
    localparam int         L4M_NUM_CFG    = 5;
    localparam logic [2:0] L4M_IDX_CTRL   = 3'h0;
    localparam logic [2:0] L4M_IDX_FLAGS  = 3'h1;
    localparam logic [2:0] L4M_IDX_SRC    = 3'h2;
    localparam logic [2:0] L4M_IDX_DST    = 3'h3;
    localparam logic [2:0] L4M_IDX_ETYPE  = 3'h4;
    localparam logic [2:0] L4M_IDX_STATUS = 3'h5;

    // control word fields
    localparam int L4M_CLS_LSB   = 0;
    localparam int L4M_PROTO_LSB = 2;
    localparam int L4M_SMODE_LSB = 4;
    localparam int L4M_DMODE_LSB = 6;
    localparam int L4M_EMODE_BIT = 8;
    // port words: low bound / exact value below, high bound above
    localparam int L4M_LO_LSB    = 0;
    localparam int L4M_HI_LSB    = 16;
    // status word fields
    localparam int L4M_ST_HIT_BIT  = 0;
    localparam int L4M_ST_EBAD_BIT = 1;
    localparam int L4M_ST_CNT_LSB  = 16;

    // tcp flag positions as in the tcp header
    localparam int L4M_FIN = 0;
    localparam int L4M_SYN = 1;
    localparam int L4M_RST = 2;
    localparam int L4M_PSH = 3;
    localparam int L4M_ACK = 4;
    localparam int L4M_URG = 5;
    localparam int L4M_NFLAGS = 6;

    localparam logic [31:0] L4M_WMASK [L4M_NUM_CFG] = '{
        32'h0000_01FF, 32'h0000_0FFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF};
    localparam logic [31:0] L4M_RESET [L4M_NUM_CFG] = '{
        32'h0000_0000, 32'h0000_0AAA, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    localparam logic [15:0] L4M_ETYPE_MIN  = 16'h0600;
    localparam logic [15:0] L4M_ETYPE_IPV4 = 16'h0800;
    localparam logic [15:0] L4M_ETYPE_ARP  = 16'h0806;
    localparam logic [15:0] L4M_ETYPE_IPV6 = 16'h86DD;
    localparam logic [15:0] L4M_CNT_MAX    = 16'hFFFF;

    typedef enum logic [1:0] {L4M_CLS_ANY = 2'b00, L4M_CLS_ETYPE = 2'b01,
                              L4M_CLS_IP = 2'b11} l4m_class_type;
    typedef enum logic [1:0] {L4M_PR_ANY = 2'b00, L4M_PR_UDP = 2'b01,
                              L4M_PR_TCP = 2'b11} l4m_proto_type;
    typedef enum logic [1:0] {L4M_PM_ANY = 2'b00, L4M_PM_EXACT = 2'b01,
                              L4M_PM_RANGE = 2'b11} l4m_pmode_type;
    typedef enum logic [1:0] {L4M_ST_IDLE = 2'b00, L4M_ST_ACCESS = 2'b01} l4m_state_type;

    function automatic logic l4m_port_hit(input logic [1:0]  mode,
                                          input logic [15:0] port,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic r;
        r = 1'b0;
        case (mode)
            L4M_PM_ANY:   r = 1'b1;
            L4M_PM_EXACT: r = (port == lo);
            L4M_PM_RANGE: r = (port >= lo) && (port <= hi);
            default:      r = 1'b0;
        endcase
        return r;
    endfunction : l4m_port_hit

    // selector 00 = must be clear, 01 = must be set, 1x = don't care
    function automatic logic l4m_flag_ok(input logic [1:0] sel, input logic flag);
        return sel[1] | (sel[0] == flag);
    endfunction : l4m_flag_ok

    function automatic logic l4m_etype_legal(input logic [15:0] v);
        return (v >= L4M_ETYPE_MIN) && (v != L4M_ETYPE_IPV4) &&
               (v != L4M_ETYPE_ARP) && (v != L4M_ETYPE_IPV6);
    endfunction : l4m_etype_legal

    function automatic logic [31:0] l4m_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r & mask;
    endfunction : l4m_merge

endpackage : l4m_pkg

`default_nettype wire

/* File: design/l4m_cfg_if.sv */
`default_nettype none

interface l4m_cfg_if;
    import l4m_pkg::*;
    logic [1:0]  cls;
    logic [1:0]  proto;
    logic [1:0]  smode;
    logic [1:0]  dmode;
    logic        emode;
    logic [11:0] flag_sel;
    logic [15:0] src_lo;
    logic [15:0] src_hi;
    logic [15:0] dst_lo;
    logic [15:0] dst_hi;
    logic [15:0] etype_val;
    logic        f_tcp;
    logic        f_udp;
    logic [15:0] f_src;
    logic [15:0] f_dst;
    logic [5:0]  f_flags;
    logic [15:0] f_etype;
    logic        match;
    logic        etype_bad;

    modport top (output cls, proto, smode, dmode, emode, flag_sel, src_lo, src_hi,
                 dst_lo, dst_hi, etype_val, f_tcp, f_udp, f_src, f_dst, f_flags, f_etype,
                 input match, etype_bad);
    modport cmp (input cls, proto, smode, dmode, emode, flag_sel, src_lo, src_hi,
                 dst_lo, dst_hi, etype_val, f_tcp, f_udp, f_src, f_dst, f_flags, f_etype,
                 output match, etype_bad);
endinterface : l4m_cfg_if

`default_nettype wire

/* File: design/l4m_cmp.sv */
`default_nettype none

module l4m_cmp
    import l4m_pkg::*;
(
    l4m_cfg_if.cmp cfg
);

    logic l4_ok;
    logic flags_ok;
    logic etype_ok;

    always_comb
    begin
        flags_ok = 1'b1;
        for (int i = 0; i < L4M_NFLAGS; i++)
        begin
            flags_ok = flags_ok & l4m_flag_ok(cfg.flag_sel[2*i +: 2], cfg.f_flags[i]);
        end
    end

    always_comb
    begin
        l4_ok = 1'b0;
        case (cfg.proto)
            L4M_PR_ANY: l4_ok = 1'b1;
            L4M_PR_UDP: l4_ok = cfg.f_udp
                && l4m_port_hit(cfg.smode, cfg.f_src, cfg.src_lo, cfg.src_hi)
                && l4m_port_hit(cfg.dmode, cfg.f_dst, cfg.dst_lo, cfg.dst_hi);
            L4M_PR_TCP: l4_ok = cfg.f_tcp && flags_ok
                && l4m_port_hit(cfg.smode, cfg.f_src, cfg.src_lo, cfg.src_hi)
                && l4m_port_hit(cfg.dmode, cfg.f_dst, cfg.dst_lo, cfg.dst_hi);
            default:    l4_ok = 1'b0;
        endcase
    end

    // with emode set, an illegal programmed value can never hit
    assign cfg.etype_bad = cfg.emode && !l4m_etype_legal(cfg.etype_val);
    assign etype_ok = !cfg.emode
                      || (!cfg.etype_bad && cfg.f_etype == cfg.etype_val);

    always_comb
    begin
        cfg.match = 1'b0;
        case (cfg.cls)
            L4M_CLS_ANY:   cfg.match = 1'b1;
            L4M_CLS_ETYPE: cfg.match = etype_ok;
            L4M_CLS_IP:    cfg.match = l4_ok;
            default:       cfg.match = 1'b0;
        endcase
    end

endmodule : l4m_cmp

`default_nettype wire

/* File: bench/l4m_parser_model.sv */
`default_nettype none

module l4m_parser_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req,
    input  wire logic [1:0]  req_kind,
    input  wire logic [15:0] req_src,
    input  wire logic [15:0] req_dst,
    input  wire logic [5:0]  req_flags,
    input  wire logic [15:0] req_etype,
    output logic             frame_valid,
    output logic             frame_is_tcp,
    output logic             frame_is_udp,
    output logic [15:0]      frame_src_port,
    output logic [15:0]      frame_dst_port,
    output logic [5:0]       frame_tcp_flags,
    output logic [15:0]      frame_ethertype
);
    timeunit 1ns;
    timeprecision 1ps;

    // between frames the fields toggle so that stale values never look valid
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_valid <= 1'b0;
            {frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port} <= '0;
            {frame_tcp_flags, frame_ethertype} <= '0;
        end
        else if (req)
        begin
            frame_valid <= 1'b1;
            {frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port} <=
                {req_kind, req_src, req_dst};
            {frame_tcp_flags, frame_ethertype} <= {req_flags, req_etype};
        end
        else
        begin
            frame_valid <= 1'b0;
            {frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port} <=
                ~{frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port};
            {frame_tcp_flags, frame_ethertype} <= ~{frame_tcp_flags, frame_ethertype};
        end
    end

endmodule : l4m_parser_model

`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import l4m_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, req;
    logic        frame_valid, frame_is_tcp, frame_is_udp, hit_valid, hit;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [1:0]  req_kind;
    logic [15:0] req_src, req_dst, req_etype, frame_src_port, frame_dst_port, frame_ethertype;
    logic [5:0]  req_flags, frame_tcp_flags;
    int          cfg [5];
    int          seed = 6553;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          hit_cnt, last_hit;
    bit          pend_v, pend_e;

    l4m_port_flag_etype_matcher #(.ADDR_W(8)) l4m_port_flag_etype_matcher_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .frame_is_tcp(frame_is_tcp), .frame_is_udp(frame_is_udp),
        .frame_src_port(frame_src_port), .frame_dst_port(frame_dst_port),
        .frame_tcp_flags(frame_tcp_flags), .frame_ethertype(frame_ethertype),
        .hit_valid(hit_valid), .hit(hit));
    l4m_parser_model l4m_parser_model_i (.pclk(pclk), .presetn(presetn), .req(req),
        .req_kind(req_kind), .req_src(req_src), .req_dst(req_dst), .req_flags(req_flags),
        .req_etype(req_etype), .frame_valid(frame_valid), .frame_is_tcp(frame_is_tcp),
        .frame_is_udp(frame_is_udp), .frame_src_port(frame_src_port),
        .frame_dst_port(frame_dst_port), .frame_tcp_flags(frame_tcp_flags),
        .frame_ethertype(frame_ethertype));

    function automatic bit port_ok(int m, int p, int w);
        int lo = w & 32'h0000_FFFF;
        int hi = (w >> 16) & 32'h0000_FFFF;
        return m == 0 || (m == 1 && p == lo) || (m == 3 && p >= lo && p <= hi);
    endfunction : port_ok

    function automatic bit et_ok(int v);
        return v >= 32'h0600 && v != 32'h0800 && v != 32'h0806 && v != 32'h86DD;
    endfunction : et_ok

    function automatic bit ref_hit(bit tcp, bit udp, int s, int d, int f, int e);
        int cl = cfg[0] & 3;
        int pr = (cfg[0] >> 2) & 3;
        bit fl = 1'b1;
        for (int i = 0; i < 6; i++)
            fl &= ((cfg[1] >> (2 * i)) & 2) != 0 || ((cfg[1] >> (2 * i)) & 1) == ((f >> i) & 1);
        if (cl == 0)
            return 1'b1;
        if (cl == 1)
            return !cfg[0][8] || (et_ok(cfg[4]) && e == cfg[4]);
        if (cl != 3 || pr == 2)
            return 1'b0;
        if (pr == 0)
            return 1'b1;
        return (pr == 1 ? udp : tcp && fl) && port_ok((cfg[0] >> 4) & 3, s, cfg[2])
            && port_ok((cfg[0] >> 6) & 3, d, cfg[3]);
    endfunction : ref_hit

    function automatic logic [15:0] near(int w);
        case ($random(seed) & 7)
            0, 1: return w[15:0];
            2: return w[31:16];
            3: return w[15:0] - 16'h0001;
            4: return w[31:16] + 16'h0001;
            default: return 16'($random(seed));
        endcase
    endfunction : near

    function automatic logic [1:0] code();
        logic [1:0] tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        return tab[$unsigned($random(seed)) % 4];
    endfunction : code

    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic apb(bit w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        check("pready wait", n, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic exp_err);
        logic [31:0] rd;
        logic        err;
        int          i = a >> 2;
        apb(1'b1, a, d, s, rd, err);
        check("write error", err, exp_err);
        if (!exp_err && i < 5)
        begin
            for (int b = 0; b < 4; b++)
                if (s[b])
                    cfg[i][8*b +: 8] = d[8*b +: 8];
            cfg[i] = cfg[i] & L4M_WMASK[i];
        end
    endtask : wr

    task automatic rd_chk(logic [7:0] a, logic [31:0] exp, logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, 4'h0, rd, err);
        check("read data", rd, exp);
        check("read error", err, exp_err);
    endtask : rd_chk

    task automatic frames(int n);
        for (int k = 0; k < n; k++)
        begin
            @(posedge pclk);
            req <= ($random(seed) % 4) != 0;
            req_kind <= 2'($unsigned($random(seed)) % 3);
            req_src <= near(cfg[2]);
            req_dst <= near(cfg[3]);
            req_flags <= 6'($random(seed));
            req_etype <= ($random(seed) & 1) ? cfg[4][15:0] : 16'($random(seed));
        end
        @(posedge pclk);
        req <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : frames

    task automatic status_chk();
        rd_chk(L4M_STATUS_OFS, {hit_cnt[15:0], 14'h0, cfg[0][8] && !et_ok(cfg[4]), last_hit[0]}, 1'b0);
    endtask : status_chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // every frame answer is compared one cycle after its frame stands
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_v = 1'b0;
            hit_cnt = 0;
            last_hit = 0;
        end
        else
        begin
            check("hit_valid", hit_valid, pend_v);
            check("hit", hit, pend_v & pend_e);
            // status bit 0 mirrors the hit output, not a sticky result
            last_hit = pend_v & pend_e;
            if (pend_v && pend_e && hit_cnt < 65535)
                hit_cnt++;
            pend_v = frame_valid;
            pend_e = ref_hit(frame_is_tcp, frame_is_udp, frame_src_port, frame_dst_port,
                             frame_tcp_flags, frame_ethertype);
        end
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, req} = '0;
        {req_kind, req_src, req_dst, req_flags, req_etype} = '0;
        foreach (cfg[i]) cfg[i] = L4M_RESET[i];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(8'(4 * i), (i < 5) ? L4M_RESET[i] : 32'h0, 1'b0);
        $display("test reset_values done");
        wr(L4M_CTRL_OFS, 32'hFFFF_FFFF, 4'hF, 1'b0);
        rd_chk(L4M_CTRL_OFS, 32'h0000_01FF, 1'b0);
        wr(L4M_SRC_OFS, 32'h0, 4'hF, 1'b0);
        wr(L4M_SRC_OFS, 32'hAABB_CCDD, 4'h3, 1'b0);
        rd_chk(L4M_SRC_OFS, 32'h0000_CCDD, 1'b0);
        wr(L4M_STATUS_OFS, 32'hFFFF_FFFF, 4'hF, 1'b0);
        status_chk();
        wr(8'h18, 32'h1234_5678, 4'hF, 1'b1);
        rd_chk(8'h02, 32'h0, 1'b1);
        $display("test register_access done");
        repeat (60)
        begin
            wr(L4M_CTRL_OFS, {23'h0, 1'($random(seed)), code(), code(), code(), code()}, 4'hF, 1'b0);
            wr(L4M_FLAGS_OFS, $random(seed), 4'hF, 1'b0);
            wr(L4M_SRC_OFS, $random(seed), 4'hF, 1'b0);
            wr(L4M_DST_OFS, $random(seed), 4'hF, 1'b0);
            wr(L4M_ETYPE_OFS, near({16'h86DD, 16'h0600}) ^ {15'h0, $random(seed) % 2 == 0}, 4'hF, 1'b0);
            frames(25);
            status_chk();
        end
        $display("test random_frames done");
        req <= 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        req <= 1'b0;
        foreach (cfg[i]) cfg[i] = L4M_RESET[i];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(L4M_CTRL_OFS, 32'h0, 1'b0);
        status_chk();
        frames(20);
        status_chk();
        $display("test midrun_reset done");
        finish_test();
    end

endmodule : testbench

`default_nettype wire
